// ---- design/uv_defs.svh ----
// Command codes, field layout, threshold steps and reset values
`ifndef UV_DEFS_SVH
`define UV_DEFS_SVH
// Command codes
`define CMD_WARN_LIMIT 8'h43
`define CMD_FAULT_LIMIT 8'h44
`define CMD_FAULT_ACTION 8'h45
// Fault action byte fields
`define ACT_SEL_HI 7
`define ACT_SEL_LO 6
`define RETRY_HI 5
`define RETRY_LO 3
`define DLY_HI 2
`define DLY_LO 0
`define RETRY_NONE 3'h0
`define RETRY_FOREVER 3'h7
// Shutdown delays in switching periods
`define DLY_SHORT 3'h1
`define DLY_MID 3'h3
`define DLY_LONG 3'h7
// Warning steps in percent
`define WARN_PCT_MIN 84
`define WARN_STEPS 13
`define WARN_SCALE 100
// Fault steps in per mille
`define FAULT_PM_MIN 600
`define FAULT_PM_STEP 25
`define FAULT_STEPS 14
`define FAULT_SCALE 1000
// Relative format full scale
`define REL_ONE 16'h0400
// Reset values
`define WARN_RESET 16'h0000
`define FAULT_RESET 16'h0000
`define ACTION_RESET 8'h80
`define WARN_IDX_RESET 4'h0
`define FAULT_IDX_RESET 4'h0
`endif

// ---- design/uv_pkg.sv ----
// Types shared by the undervoltage monitor modules
package uv_pkg;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_RUN = 3'b001,
    ST_DELAY = 3'b010,
    ST_HICCUP = 3'b011,
    ST_RESTART = 3'b100,
    ST_LATCHED = 3'b101
  } resp_state_t;
  typedef enum logic [1:0] {
    ACT_IGNORE = 2'b00,
    ACT_DELAYED = 2'b01,
    ACT_IMMEDIATE = 2'b10,
    ACT_INVALID = 2'b11
  } fault_action_t;
endpackage : uv_pkg

// ---- design/uv_sync2.sv ----
// Two flip-flop level synchroniser
`timescale 1ns/1ns
module uv_sync2 (
  // Destination clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Level in and out
  input wire logic d,
  output logic q
);
  logic meta;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : uv_sync2

// ---- design/uv_fault_response.sv ----
// Undervoltage fault shutdown, delay and restart sequencing
`timescale 1ns/1ns
`include "uv_defs.svh"
module uv_fault_response (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Fault, settings and timing
  input wire logic fault,
  input wire logic [7:0] action,
  input wire logic pwm_tick,
  input wire logic [15:0] rise_cycles,
  input wire logic on_cmd,
  // Converter control
  output logic power_en,
  output logic latched_off
);
  uv_pkg::resp_state_t state, next_state;
  logic [18:0] cnt, next_cnt;
  logic [2:0] tries, next_tries;
  logic next_power_en;
  logic shutdown, give_up;
  logic [1:0] sel;
  logic [2:0] retry, dly, mult, dly_ticks;
  logic [18:0] hiccup_len, restart_len;

  // Field split and sequence lengths
  assign sel = action[`ACT_SEL_HI:`ACT_SEL_LO];
  assign retry = action[`RETRY_HI:`RETRY_LO];
  assign dly = action[`DLY_HI:`DLY_LO];
  assign hiccup_len = {3'h0, rise_cycles} * {16'h0000, mult};
  assign restart_len = {2'h0, rise_cycles, 1'b0};
  assign latched_off = (state == uv_pkg::ST_LATCHED);

  // Delay and hiccup multiple from the delay field
  always_comb begin
    case (dly)
      3'h0, 3'h1: mult = 3'h1;
      3'h3: mult = 3'h4;
      3'h4: mult = 3'h6;
      default: mult = dly;
    endcase
    if (dly < 3'h2) begin
      dly_ticks = `DLY_SHORT;
    end else if (dly < 3'h5) begin
      dly_ticks = `DLY_MID;
    end else begin
      dly_ticks = `DLY_LONG;
    end
  end

  // Next state of the response sequencer
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_tries = tries;
    shutdown = 1'b0;
    give_up = (retry == `RETRY_NONE) ||
      ((retry != `RETRY_FOREVER) && (tries >= retry));
    case (state)
      uv_pkg::ST_OFF: begin
        if (on_cmd) begin
          next_state = uv_pkg::ST_RESTART;
          next_cnt = restart_len;
          next_tries = 3'h0;
        end
      end
      uv_pkg::ST_RUN, uv_pkg::ST_RESTART: begin
        if (fault && sel == uv_pkg::ACT_DELAYED) begin
          next_state = uv_pkg::ST_DELAY;
          next_cnt = {16'h0000, dly_ticks};
        end else if (fault && sel == uv_pkg::ACT_IMMEDIATE) begin
          shutdown = 1'b1;
        end else if (state == uv_pkg::ST_RESTART) begin
          if (cnt <= 19'h0_0001) begin
            next_state = uv_pkg::ST_RUN;
            next_tries = 3'h0;
          end else begin
            next_cnt = cnt - 19'h0_0001;
          end
        end
      end
      uv_pkg::ST_DELAY: begin
        if (!fault) begin
          next_state = uv_pkg::ST_RUN;
        end else if (pwm_tick) begin
          if (cnt <= 19'h0_0001) begin
            shutdown = 1'b1;
          end else begin
            next_cnt = cnt - 19'h0_0001;
          end
        end
      end
      uv_pkg::ST_HICCUP: begin
        if (cnt <= 19'h0_0001) begin
          next_state = uv_pkg::ST_RESTART;
          next_cnt = restart_len;
        end else begin
          next_cnt = cnt - 19'h0_0001;
        end
      end
      uv_pkg::ST_LATCHED: begin
        next_state = uv_pkg::ST_LATCHED;
      end
      default: begin
        next_state = uv_pkg::ST_OFF;
      end
    endcase
    if (shutdown) begin
      if (give_up) begin
        next_state = uv_pkg::ST_LATCHED;
      end else begin
        next_state = uv_pkg::ST_HICCUP;
        next_cnt = hiccup_len;
        if (retry != `RETRY_FOREVER) begin
          next_tries = tries + 3'h1;
        end
      end
    end
    if (!on_cmd) begin
      next_state = uv_pkg::ST_OFF;
      next_tries = 3'h0;
    end
    next_power_en = (next_state == uv_pkg::ST_RUN) ||
      (next_state == uv_pkg::ST_DELAY) ||
      (next_state == uv_pkg::ST_RESTART);
  end

  // Sequencer registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= uv_pkg::ST_OFF;
      cnt <= 19'h0_0000;
      tries <= 3'h0;
      power_en <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      tries <= next_tries;
      power_en <= next_power_en;
    end
  end

  // Delayed shutdown on the last tick of any delay
  sequence s_delay_last;
    state == uv_pkg::ST_DELAY &&
      cnt == 19'h0_0001;
  endsequence
  sequence s_delay_tick;
    fault && on_cmd && pwm_tick;
  endsequence
  property p_delay_one_tick;
    @(posedge core_clk) disable iff (!rstn)
    s_delay_last ##0 s_delay_tick |=> state != uv_pkg::ST_DELAY &&
      !power_en;
  endproperty
  a_delay_one_tick: assert property (p_delay_one_tick)
    else $error("delayed shutdown missed its tick");

  property p_immediate_off;
    @(posedge core_clk) disable iff (!rstn)
    (state == uv_pkg::ST_RUN && fault && on_cmd &&
      sel == uv_pkg::ACT_IMMEDIATE) |=> !power_en;
  endproperty
  a_immediate_off: assert property (p_immediate_off)
    else $error("immediate shutdown did not stop power");

  property p_latch_no_retry;
    @(posedge core_clk) disable iff (!rstn)
    (state == uv_pkg::ST_RUN && fault && on_cmd && retry == 3'h0 &&
      sel == uv_pkg::ACT_IMMEDIATE) |=> state == uv_pkg::ST_LATCHED;
  endproperty
  a_latch_no_retry: assert property (p_latch_no_retry)
    else $error("retry zero did not latch off");
endmodule : uv_fault_response

// ---- design/output_undervoltage_monitor_config.sv ----
// Undervoltage limit and response command bank with status tracking
`timescale 1ns/1ns
`include "uv_defs.svh"
module output_undervoltage_monitor_config (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Link side command port
  input wire logic link_clk,
  input wire logic link_valid,
  input wire logic link_write,
  input wire logic link_word,
  input wire logic [7:0] link_code,
  input wire logic [15:0] link_data,
  output logic link_ready,
  output logic link_rd_valid,
  output logic [15:0] link_rd_data,
  // Output voltage context
  input wire logic vout_relative,
  input wire logic [15:0] vout_command,
  input wire logic [15:0] vout_sense,
  input wire logic pwm_tick,
  input wire logic [15:0] rise_cycles,
  input wire logic on_cmd,
  input wire logic clear_faults,
  // Status and control
  output logic status_word_vout,
  output logic status_byte_none,
  output logic status_warning_limit_value,
  output logic status_fault_limit_value,
  output logic status_cml_invalid,
  output logic alert_n,
  output logic power_en,
  output logic latched_off
);
  // Link domain state
  logic lk_busy, next_lk_busy;
  logic lk_write, next_lk_write;
  logic lk_word, next_lk_word;
  logic [7:0] lk_code, next_lk_code;
  logic [15:0] lk_data, next_lk_data;
  logic req_tgl, next_req_tgl;
  logic ack_seen, next_ack_seen;
  logic next_rd_valid;
  logic [15:0] next_rd_data;
  logic ack_sync;
  // Core domain state
  logic [15:0] warn_limit, next_warn_limit;
  logic [15:0] fault_limit, next_fault_limit;
  logic [7:0] fault_action, next_fault_action;
  logic [3:0] warn_idx, next_warn_idx;
  logic [3:0] fault_idx, next_fault_idx;
  logic [15:0] rd_word, next_rd_word;
  logic ack_tgl, next_ack_tgl;
  logic req_seen, next_req_seen;
  logic next_word_vout, next_byte_none;
  logic next_uvw, next_uvf, next_cml, next_alert_n;
  logic req_sync, cmd_fire, bad_write;
  // Conversion and compare
  logic [31:0] target, scaled_w, scaled_f;
  logic warn_ok, fault_ok, action_ok;
  logic [3:0] warn_sel, fault_sel;
  logic warn_cond, fault_cond;

  // Ready while no command is in flight
  assign link_ready = !lk_busy;

  // Link side capture and completion
  always_comb begin
    next_lk_busy = lk_busy;
    next_lk_write = lk_write;
    next_lk_word = lk_word;
    next_lk_code = lk_code;
    next_lk_data = lk_data;
    next_req_tgl = req_tgl;
    next_ack_seen = ack_seen;
    next_rd_valid = 1'b0;
    next_rd_data = link_rd_data;
    if (!lk_busy && link_valid) begin
      next_lk_busy = 1'b1;
      next_lk_write = link_write;
      next_lk_word = link_word;
      next_lk_code = link_code;
      next_lk_data = link_data;
      next_req_tgl = !req_tgl;
    end else if (lk_busy && ack_sync != ack_seen) begin
      next_lk_busy = 1'b0;
      next_ack_seen = ack_sync;
      next_rd_valid = 1'b1;
      next_rd_data = rd_word; // Held stable by the handshake
    end
  end

  // Link side registers
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      lk_busy <= 1'b0;
      lk_write <= 1'b0;
      lk_word <= 1'b0;
      lk_code <= 8'h00;
      lk_data <= 16'h0000;
      req_tgl <= 1'b0;
      ack_seen <= 1'b0;
      link_rd_valid <= 1'b0;
      link_rd_data <= 16'h0000;
    end else begin
      lk_busy <= next_lk_busy;
      lk_write <= next_lk_write;
      lk_word <= next_lk_word;
      lk_code <= next_lk_code;
      lk_data <= next_lk_data;
      req_tgl <= next_req_tgl;
      ack_seen <= next_ack_seen;
      link_rd_valid <= next_rd_valid;
      link_rd_data <= next_rd_data;
    end
  end

  // Request toggle into the core domain
  uv_sync2 req_sync_inst (
    .clk(core_clk),
    .rstn(rstn),
    .d(req_tgl),
    .q(req_sync)
  );

  // Acknowledge toggle back to the link
  uv_sync2 ack_sync_inst (
    .clk(link_clk),
    .rstn(rstn),
    .d(ack_tgl),
    .q(ack_sync)
  );

  assign cmd_fire = (req_sync != req_seen);

  // Written limit to hardware step, rounding down
  always_comb begin
    target = vout_relative ? {16'h0000, `REL_ONE} :
      {16'h0000, vout_command};
    scaled_w = {16'h0000, lk_data} * 32'(`WARN_SCALE);
    scaled_f = {16'h0000, lk_data} * 32'(`FAULT_SCALE);
    warn_ok = 1'b0;
    warn_sel = `WARN_IDX_RESET;
    fault_ok = 1'b0;
    fault_sel = `FAULT_IDX_RESET;
    for (int k = 0; k <= `WARN_STEPS; k++) begin
      if (scaled_w >= target * 32'(`WARN_PCT_MIN + k)) begin
        warn_ok = 1'b1;
        warn_sel = 4'(k);
      end
    end
    for (int k = 0; k <= `FAULT_STEPS; k++) begin
      if (scaled_f >= target *
          32'(`FAULT_PM_MIN + k * `FAULT_PM_STEP)) begin
        fault_ok = 1'b1;
        fault_sel = 4'(k);
      end
    end
    // At or above the target itself is not a low limit
    if (scaled_w >= target * 32'(`WARN_SCALE)) begin
      warn_ok = 1'b0;
    end
    if (scaled_f >= target * 32'(`FAULT_SCALE)) begin
      fault_ok = 1'b0;
    end
    action_ok = lk_data[`ACT_SEL_HI:`ACT_SEL_LO] !=
      uv_pkg::ACT_INVALID;
  end

  // Live thresholds against the present target
  assign warn_cond = power_en && ({16'h0000, vout_sense} *
    32'(`WARN_SCALE) < {16'h0000, vout_command} *
    (32'(`WARN_PCT_MIN) + {28'h000_0000, warn_idx}));
  assign fault_cond = power_en && ({16'h0000, vout_sense} *
    32'(`FAULT_SCALE) < {16'h0000, vout_command} *
    (32'(`FAULT_PM_MIN) + {28'h000_0000, fault_idx} *
    32'(`FAULT_PM_STEP)));

  // Command decode, register update and status flags
  always_comb begin
    next_warn_limit = warn_limit;
    next_fault_limit = fault_limit;
    next_fault_action = fault_action;
    next_warn_idx = warn_idx;
    next_fault_idx = fault_idx;
    next_rd_word = rd_word;
    next_ack_tgl = ack_tgl;
    next_req_seen = req_seen;
    bad_write = 1'b0;
    if (cmd_fire) begin
      next_req_seen = req_sync;
      next_ack_tgl = !ack_tgl;
      next_rd_word = 16'h0000;
      case (lk_code)
        `CMD_WARN_LIMIT: begin
          next_rd_word = warn_limit;
          if (lk_write && lk_word && warn_ok) begin
            next_warn_limit = lk_data;
            next_warn_idx = warn_sel;
          end else if (lk_write) begin
            bad_write = 1'b1;
          end
        end
        `CMD_FAULT_LIMIT: begin
          next_rd_word = fault_limit;
          if (lk_write && lk_word && fault_ok) begin
            next_fault_limit = lk_data;
            next_fault_idx = fault_sel;
          end else if (lk_write) begin
            bad_write = 1'b1;
          end
        end
        `CMD_FAULT_ACTION: begin
          next_rd_word = {8'h00, fault_action};
          if (lk_write && !lk_word && action_ok) begin
            next_fault_action = lk_data[7:0];
          end else if (lk_write) begin
            bad_write = 1'b1;
          end
        end
        default: begin
          next_rd_word = 16'h0000;
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    next_uvw = warn_cond || (status_warning_limit_value && !clear_faults);
    next_uvf = fault_cond || (status_fault_limit_value && !clear_faults);
    next_byte_none = fault_cond ||
      (status_byte_none && !clear_faults);
    next_word_vout = warn_cond || fault_cond ||
      (status_word_vout && !clear_faults);
    next_cml = bad_write ||
      (status_cml_invalid && !clear_faults);
    next_alert_n = !(next_uvw || next_uvf || next_cml);
  end

  // Core registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      warn_limit <= `WARN_RESET;
      fault_limit <= `FAULT_RESET;
      fault_action <= `ACTION_RESET;
      warn_idx <= `WARN_IDX_RESET;
      fault_idx <= `FAULT_IDX_RESET;
      rd_word <= 16'h0000;
      ack_tgl <= 1'b0;
      req_seen <= 1'b0;
      status_warning_limit_value <= 1'b0;
      status_fault_limit_value <= 1'b0;
      status_byte_none <= 1'b0;
      status_word_vout <= 1'b0;
      status_cml_invalid <= 1'b0;
      alert_n <= 1'b1;
    end else begin
      warn_limit <= next_warn_limit;
      fault_limit <= next_fault_limit;
      fault_action <= next_fault_action;
      warn_idx <= next_warn_idx;
      fault_idx <= next_fault_idx;
      rd_word <= next_rd_word;
      ack_tgl <= next_ack_tgl;
      req_seen <= next_req_seen;
      status_warning_limit_value <= next_uvw;
      status_fault_limit_value <= next_uvf;
      status_byte_none <= next_byte_none;
      status_word_vout <= next_word_vout;
      status_cml_invalid <= next_cml;
      alert_n <= next_alert_n;
    end
  end

  // Fault action sequencing
  uv_fault_response response_inst (
    .core_clk(core_clk),
    .rstn(rstn),
    .fault(fault_cond),
    .action(fault_action),
    .pwm_tick(pwm_tick),
    .rise_cycles(rise_cycles),
    .on_cmd(on_cmd),
    .power_en(power_en),
    .latched_off(latched_off)
  );

  property p_warn_flags;
    @(posedge core_clk) disable iff (!rstn)
    warn_cond |=> status_warning_limit_value && status_word_vout && !alert_n;
  endproperty
  a_warn_flags: assert property (p_warn_flags)
    else $error("warning did not set its flags");

  property p_fault_flags;
    @(posedge core_clk) disable iff (!rstn)
    fault_cond |=> status_fault_limit_value && status_byte_none &&
      status_word_vout && !alert_n;
  endproperty
  a_fault_flags: assert property (p_fault_flags)
    else $error("fault did not set its flags");

  property p_sticky;
    @(posedge core_clk) disable iff (!rstn)
    status_warning_limit_value && !clear_faults |=> status_warning_limit_value;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("warning flag dropped without a clear");

  property p_bad_action;
    @(posedge core_clk) disable iff (!rstn)
    cmd_fire && lk_write && lk_code == `CMD_FAULT_ACTION &&
      !action_ok |=> status_cml_invalid &&
      fault_action == $past(fault_action);
  endproperty
  a_bad_action: assert property (p_bad_action)
    else $error("invalid action byte was taken");

  property p_warn_store;
    @(posedge core_clk) disable iff (!rstn)
    cmd_fire && lk_write && lk_word && lk_code == `CMD_WARN_LIMIT &&
      warn_ok |=> warn_limit == $past(lk_data) && warn_idx == $past(warn_sel)
      ##1 rd_word == $past(rd_word) && warn_limit == $past(warn_limit);
  endproperty
  a_warn_store: assert property (p_warn_store)
    else $error("valid warning limit not stored");
endmodule : output_undervoltage_monitor_config

// ---- dv/uv_link_host.sv ----
// Link host model issuing one command at a time
`timescale 1ns/1ns
module uv_link_host (
  // Link clock and answer
  input wire logic link_clk,
  input wire logic link_ready,
  input wire logic link_rd_valid,
  input wire logic [15:0] link_rd_data,
  // Command offer
  output logic link_valid,
  output logic link_write,
  output logic link_word,
  output logic [7:0] link_code,
  output logic [15:0] link_data
);
  // Idle offer before the first command
  initial begin
    link_valid = 1'b0;
    link_write = 1'b0;
    link_word = 1'b0;
    link_code = 8'h00;
    link_data = 16'h0000;
  end
  // Offer while ready, hold over the taking edge, then scramble
  task automatic xfer(input logic wr, input logic wd, input logic [7:0] code,
    input logic [15:0] d, output logic [15:0] rd);
    int n;
    rd = 16'hxxxx;
    n = 0;
    @(negedge link_clk);
    while (link_ready !== 1'b1 && n < 50) begin
      @(negedge link_clk);
      n++;
    end
    link_valid = 1'b1;
    link_write = wr;
    link_word = wd;
    link_code = code;
    link_data = d;
    @(negedge link_clk);
    link_valid = 1'b0;
    link_write = ~wr;
    link_word = ~wd;
    link_code = ~code;
    link_data = ~d;
    n = 0;
    while (link_rd_valid !== 1'b1 && n < 50) begin
      @(negedge link_clk);
      link_data = ~link_data;
      n++;
    end
    if (n < 50) rd = link_rd_data;
  endtask : xfer
endmodule : uv_link_host

// ---- dv/output_undervoltage_monitor_config_bench.sv ----
// Self-checking bench for the undervoltage command bank
`timescale 1ns/1ns
module output_undervoltage_monitor_config_bench;
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rstn = 1'b0;
  logic link_valid, link_write, link_word, link_ready, link_rd_valid;
  logic [7:0] link_code;
  logic [15:0] link_data, link_rd_data;
  logic vout_relative = 1'b0;
  logic [15:0] vout_command = 16'h1000;
  logic [15:0] vout_sense = 16'h1000;
  logic pwm_tick = 1'b0;
  logic [15:0] rise_cycles = 16'h0010;
  logic on_cmd = 1'b0;
  logic clear_faults = 1'b0;
  logic status_word_vout, status_byte_none, status_warning_limit_value;
  logic status_fault_limit_value, status_cml_invalid, alert_n, power_en, latched_off;
  int err_total = 0;
  int check_count = 0;
  int seed = 32'h8735;
  int cmd, lo, w, k, thr;
  logic [15:0] mdl [4];
  logic [7:0] act [3] = '{8'h00, 8'h40, 8'h80};
  // Clocks, link one unrelated in phase
  always #5 core_clk = ~core_clk;
  initial begin
    #2;
    forever #3 link_clk = ~link_clk;
  end
  output_undervoltage_monitor_config output_undervoltage_monitor_config_inst (
    .core_clk(core_clk), .rstn(rstn), .link_clk(link_clk),
    .link_valid(link_valid), .link_write(link_write),
    .link_word(link_word), .link_code(link_code), .link_data(link_data),
    .link_ready(link_ready), .link_rd_valid(link_rd_valid),
    .link_rd_data(link_rd_data), .vout_relative(vout_relative),
    .vout_command(vout_command), .vout_sense(vout_sense),
    .pwm_tick(pwm_tick), .rise_cycles(rise_cycles), .on_cmd(on_cmd),
    .clear_faults(clear_faults), .status_word_vout(status_word_vout),
    .status_byte_none(status_byte_none),
    .status_warning_limit_value(status_warning_limit_value), .status_fault_limit_value(status_fault_limit_value),
    .status_cml_invalid(status_cml_invalid), .alert_n(alert_n),
    .power_en(power_en), .latched_off(latched_off));
  uv_link_host uv_link_host_inst (
    .link_clk(link_clk), .link_ready(link_ready),
    .link_rd_valid(link_rd_valid), .link_rd_data(link_rd_data),
    .link_valid(link_valid), .link_write(link_write),
    .link_word(link_word), .link_code(link_code), .link_data(link_data));
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Status bits packed with the alert line
  function automatic logic [15:0] st();
    return {10'h000, status_word_vout, status_byte_none, status_warning_limit_value,
      status_fault_limit_value, status_cml_invalid, alert_n};
  endfunction : st
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  // One core cycle tick pulse per switching period
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge core_clk) pwm_tick = 1'b1;
      @(negedge core_clk) pwm_tick = 1'b0;
    end
  endtask : tick
  task automatic clr();
    @(negedge core_clk) clear_faults = 1'b1;
    @(negedge core_clk) clear_faults = 1'b0;
  endtask : clr
  // One command against the model; every answer returns the old value
  task automatic acc(input logic wr, input logic wd, input logic [7:0] code,
    input logic [15:0] d, input bit ok);
    logic [15:0] rd;
    int i;
    i = (code >= 8'h43 && code <= 8'h45) ? code - 8'h43 : 3;
    uv_link_host_inst.xfer(wr, wd, code, d, rd);
    chk(rd, mdl[i]);
    if (wr && ok && i < 3) mdl[i] = d;
    cyc(1);
  endtask : acc
  // Refused write, flag, clear, unchanged readback
  task automatic bad(input logic wd, input logic [7:0] code,
    input logic [15:0] d);
    acc(1'b1, wd, code, d, 1'b0);
    cyc(4);
    chk(st(), 16'h0002);
    clr();
    cyc(3);
    chk(st(), 16'h0001);
    acc(1'b0, 1'b1, code, 16'h0000, 1'b1);
  endtask : bad
  task automatic complete_run();
    if (err_total == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  // Watchdog
  initial begin
    #300000;
    err_total++;
    complete_run();
  end
  // Main sequence
  initial begin
    mdl = '{16'h0000, 16'h0000, 16'h0080, 16'h0000};
    cmd = 4096;
    cyc(12);
    rstn = 1'b1;
    cyc(2);
    chk(st(), 16'h0001);
    chk({15'h0000, power_en}, 16'h0000);
    acc(1'b0, 1'b1, 8'h43, 16'h0000, 1'b1);
    acc(1'b0, 1'b1, 8'h44, 16'h0000, 1'b1);
    acc(1'b0, 1'b0, 8'h45, 16'h0000, 1'b1);
    acc(1'b0, 1'b1, 8'h50, 16'h0000, 1'b1);
    // Random in-range limits, warning anywhere, fault in lowest step
    lo = (cmd * 84 + 99) / 100;
    w = lo + $unsigned($random(seed)) % (cmd - lo);
    acc(1'b1, 1'b1, 8'h43, 16'(w), 1'b1);
    acc(1'b0, 1'b1, 8'h43, 16'h0000, 1'b1);
    lo = (cmd * 600 + 999) / 1000;
    w = lo + $unsigned($random(seed)) % 20;
    acc(1'b1, 1'b1, 8'h44, 16'(w), 1'b1);
    acc(1'b0, 1'b1, 8'h44, 16'h0000, 1'b1);
    foreach (act[i]) acc(1'b1, 1'b0, 8'h45, {8'h00, act[i]}, 1'b1);
    acc(1'b0, 1'b0, 8'h45, 16'h0000, 1'b1);
    // Stored limit survives a target change
    vout_command = 16'h1100;
    cyc(3);
    acc(1'b0, 1'b1, 8'h43, 16'h0000, 1'b1);
    vout_command = 16'h1000;
    bad(1'b1, 8'h43, 16'h0001);
    bad(1'b1, 8'h44, 16'h1000);
    bad(1'b0, 8'h45, 16'h00c0);
    bad(1'b0, 8'h43, 16'h0f00);
    // Warning threshold from the rounded-down step
    k = 13;
    while (int'(mdl[0]) * 100 < cmd * (84 + k)) k--;
    thr = cmd * (84 + k) / 100;
    on_cmd = 1'b1;
    cyc(60);
    chk({15'h0000, power_en}, 16'h0001);
    vout_sense = 16'(thr + 3);
    cyc(4);
    chk(st(), 16'h0001);
    vout_sense = 16'(thr - 3);
    cyc(4);
    chk(st(), 16'h0028);
    vout_sense = 16'(cmd);
    cyc(4);
    chk(st(), 16'h0028);
    clr();
    cyc(3);
    chk(st(), 16'h0001);
    // Relative format, 0x03e0 of 0x0400 rounds down to the 96 step
    vout_relative = 1'b1;
    acc(1'b1, 1'b1, 8'h43, 16'h03e0, 1'b1);
    bad(1'b1, 8'h43, 16'h0400);
    vout_sense = 16'(cmd * 96 / 100 + 3);
    cyc(4);
    chk(st(), 16'h0001);
    vout_sense = 16'(cmd * 96 / 100 - 3);
    cyc(4);
    chk(st(), 16'h0028);
    vout_sense = 16'(cmd);
    vout_relative = 1'b0;
    // Fault with each action code, one switching period of delay
    foreach (act[i]) begin
      acc(1'b1, 1'b0, 8'h45, {8'h00, act[i]}, 1'b1);
      on_cmd = 1'b0;
      cyc(4);
      clr();
      on_cmd = 1'b1;
      cyc(60);
      vout_sense = 16'(cmd * 600 / 1000 - 3);
      cyc(4);
      chk(st(), 16'h003c);
      chk({15'h0000, power_en}, 16'(i < 2));
      tick(1);
      cyc(4);
      chk({15'h0000, power_en}, 16'(i == 0));
      chk({15'h0000, latched_off}, 16'(i > 0));
      vout_sense = 16'(cmd);
    end
    // Delayed action, one restart, three periods, hiccup of four rises
    acc(1'b1, 1'b0, 8'h45, 16'h004b, 1'b1);
    on_cmd = 1'b0;
    cyc(4);
    clr();
    on_cmd = 1'b1;
    cyc(60);
    vout_sense = 16'(cmd * 600 / 1000 - 3);
    cyc(2);
    tick(1);
    cyc(2);
    chk({15'h0000, power_en}, 16'h0001);
    tick(2);
    cyc(2);
    chk({14'h0000, power_en, latched_off}, 16'h0000);
    cyc(70);
    chk({14'h0000, power_en, latched_off}, 16'h0002);
    tick(3);
    cyc(2);
    chk({14'h0000, power_en, latched_off}, 16'h0001);
    vout_sense = 16'(cmd);
    complete_run();
  end
endmodule : output_undervoltage_monitor_config_bench
